// ### pkg/switch_pkg.sv
// constants and types shared by the switching engine files
`default_nettype none
package switch_pkg;
    // shared frame buffer pool
    localparam int BUF_COUNT = 256;
    localparam int BUF_BYTES = 128;
    localparam int DESC_DEPTH = 16;
    // register bus
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_PORT_ONE_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PORT_TWO_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_POOL_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_DROP_COUNT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_FWD_COUNT = 8'h10;
    // port control fields
    localparam int LRN_DIS_BIT = 0;
    localparam int RX_EN_BIT = 1;
    localparam int TX_EN_BIT = 2;
    localparam int CTRL_W = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h6;
    // pool status fields
    localparam int ST_FREE_LSB = 0;
    localparam int ST_QUEUED_LSB = 16;
    localparam int CNT_W = 16;
    // port codes and destination mask bits
    localparam logic [1:0] PORT_ONE = 2'h1;
    localparam logic [1:0] PORT_TWO = 2'h2;
    localparam logic [1:0] PORT_HOST = 2'h3;
    localparam logic [2:0] MASK_ONE = 3'h1;
    localparam logic [2:0] MASK_TWO = 3'h2;
    localparam logic [2:0] MASK_HOST = 3'h4;
    localparam logic [2:0] MASK_NONE = 3'h0;

    typedef enum logic [1:0] {
        ING_IDLE = 2'b01,
        ING_RECV = 2'b10
    } ing_state_t;

    typedef enum logic [1:0] {
        EGR_IDLE = 2'b01,
        EGR_SEND = 2'b10
    } egr_state_t;
endpackage : switch_pkg
`default_nettype wire

// ### verilog/desc_fifo.sv
// frame descriptor queue between ingress commit and egress
`default_nettype none
module desc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // fill side
    input wire logic push,
    input wire logic [WIDTH-1:0] din,
    output logic full,
    // drain side
    input wire logic pop,
    output logic [WIDTH-1:0] dout,
    output logic empty,
    // occupancy
    output logic [CW-1:0] count
);
    localparam int IW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [IW-1:0] wr_q;
    logic [IW-1:0] rd_q;
    logic [CW-1:0] cnt_q;

    wire do_push = push && !full;
    wire do_pop = pop && !empty;

    assign full = cnt_q == CW'(DEPTH);
    assign empty = cnt_q == '0;
    assign count = cnt_q;
    assign dout = mem_q[rd_q];

    function automatic logic [IW-1:0] bump(input logic [IW-1:0] p);
        return (p == IW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_ff @(posedge hclk) begin
        if (do_push) begin
            mem_q[wr_q] <= din;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= bump(wr_q);
            end
            if (do_pop) begin
                rd_q <= bump(rd_q);
            end
            cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule : desc_fifo
`default_nettype wire

// ### verilog/switch_stp_engine.sv
// store-and-forward engine with spanning tree gating of ports one and two
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`default_nettype none
module switch_stp_engine
    import switch_pkg::*;
#(
    parameter int N_BUF = BUF_COUNT,
    parameter int BUF_SZ = BUF_BYTES,
    parameter int N_DESC = DESC_DEPTH
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // register bus
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // ingress byte stream with lookup result at the last byte
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic [1:0] rx_port,
    input wire logic [2:0] rx_dest,
    input wire logic rx_override,
    // egress byte stream with destination mask
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic [2:0] tx_mask,
    // source address learning request
    output logic learn_valid,
    output logic [1:0] learn_port
);
    localparam int PW = $clog2(N_BUF);
    localparam int OW = $clog2(BUF_SZ);
    localparam int AW = PW + OW;
    localparam int LW = AW + 1;
    localparam int CW = PW + 1;
    localparam int DW = PW + LW + CW + 3;
    localparam int QW = $clog2(N_DESC + 1);

    ing_state_t ing_q;
    egr_state_t egr_q;
    logic [CTRL_W-1:0] ctrl1_q;
    logic [CTRL_W-1:0] ctrl2_q;
    logic [CTRL_W-1:0] snap1_q;
    logic [CTRL_W-1:0] snap2_q;
    logic [7:0] mem_q [N_BUF*BUF_SZ];
    logic [PW-1:0] np_q;
    logic [PW-1:0] cur_q;
    logic [OW-1:0] off_q;
    logic [PW-1:0] start_q;
    logic [LW-1:0] flen_q;
    logic [CW-1:0] fpg_q;
    logic [CW-1:0] free_q;
    logic [LW-1:0] idx_q;
    logic [7:0] tx_data_q;
    logic learn_valid_q;
    logic [1:0] learn_port_q;
    logic [CNT_W-1:0] drop_q;
    logic [CNT_W-1:0] fwd_q;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [ADDR_W-1:0] a_q;

    // one-byte fetch address inside a chain of consecutive buffers
    function automatic logic [AW-1:0] byte_addr(
        input logic [PW-1:0] pg,
        input logic [LW-1:0] idx
    );
        logic [PW-1:0] p;
        p = pg + idx[AW-1:OW];
        return {p, idx[OW-1:0]};
    endfunction : byte_addr

    function automatic logic [2:0] src_bit(input logic [1:0] src);
        return (src == PORT_ONE) ? MASK_ONE :
               (src == PORT_TWO) ? MASK_TWO : MASK_HOST;
    endfunction : src_bit

    // spanning tree gate on a finished frame's destination mask
    function automatic logic [2:0] stp_gate(
        input logic [1:0] src,
        input logic [2:0] dest,
        input logic ovr,
        input logic [CTRL_W-1:0] c1,
        input logic [CTRL_W-1:0] c2
    );
        logic [2:0] tx_ok;
        logic rx_on;
        logic [2:0] m;
        tx_ok = {1'b1, c2[TX_EN_BIT], c1[TX_EN_BIT]};
        rx_on = (src == PORT_ONE) ? c1[RX_EN_BIT] : c2[RX_EN_BIT];
        m = MASK_NONE;
        if (src == PORT_HOST) begin
            // processor frames reach any network port in any state
            m = dest & ~MASK_HOST;
        end else if (src == PORT_ONE || src == PORT_TWO) begin
            if (!rx_on) begin
                m = ovr ? MASK_HOST : MASK_NONE;
            end else begin
                m = (dest | (ovr ? MASK_HOST : MASK_NONE)) & tx_ok
                    & ~src_bit(src);
            end
        end
        return m;
    endfunction : stp_gate

    function automatic logic learn_on(
        input logic [1:0] src,
        input logic [CTRL_W-1:0] c1,
        input logic [CTRL_W-1:0] c2
    );
        return (src == PORT_ONE) ? !c1[LRN_DIS_BIT] :
               (src == PORT_TWO) ? !c2[LRN_DIS_BIT] :
               (src == PORT_HOST);
    endfunction : learn_on

    // ingress: controls frozen from the first byte to the last
    wire in_frame = ing_q == ING_RECV;
    wire [CTRL_W-1:0] eff1 = in_frame ? snap1_q : ctrl1_q;
    wire [CTRL_W-1:0] eff2 = in_frame ? snap2_q : ctrl2_q;
    wire alloc = off_q == '0;
    wire desc_full;
    wire desc_empty;
    wire [DW-1:0] desc_out;
    wire [QW-1:0] desc_cnt;
    // a new buffer is taken only when one is free, else the source waits
    // limitation: a frame longer than the whole pool stalls for good
    assign rx_ready = !desc_full && !(alloc && free_q == '0);
    wire wr_fire = rx_valid && rx_ready;
    wire end_fire = wr_fire && rx_last;
    wire [AW-1:0] wr_addr = alloc ? {np_q, OW'(0)} : {cur_q, off_q};
    wire [2:0] fwd_mask = stp_gate(rx_port, rx_dest, rx_override,
                                   eff1, eff2);
    wire commit = end_fire && fwd_mask != MASK_NONE;
    wire discard = end_fire && fwd_mask == MASK_NONE;
    wire [CW-1:0] pg_now = fpg_q + CW'(alloc);
    wire [LW-1:0] len_now = flen_q + LW'(1);
    wire [PW-1:0] fstart = in_frame ? start_q : np_q;
    wire [DW-1:0] desc_in = {fstart, len_now, pg_now, fwd_mask};

    // egress: only committed frames are ever visible here
    wire [PW-1:0] d_start = desc_out[DW-1 -: PW];
    wire [LW-1:0] d_len = desc_out[LW+CW+2 -: LW];
    wire [CW-1:0] d_pg = desc_out[CW+2 -: CW];
    wire egr_send = egr_q == EGR_SEND;
    wire egr_start = egr_q == EGR_IDLE && !desc_empty;
    wire at_last = idx_q == d_len - LW'(1);
    wire tx_fire = egr_send && tx_ready;
    wire release_fr = tx_fire && at_last;
    wire [LW-1:0] idx_next = egr_start ? '0 : idx_q + LW'(1);

    assign tx_valid = egr_send;
    assign tx_data = tx_data_q;
    assign tx_last = egr_send && at_last;
    // queue head stays put until release, so the mask needs no copy
    assign tx_mask = egr_send ? desc_out[2:0] : MASK_NONE;
    assign learn_valid = learn_valid_q;
    assign learn_port = learn_port_q;

    // pool bookkeeping: buffers go back on drop or after transmission
    wire [CW-1:0] free_d = free_q - CW'(wr_fire && alloc)
        + (discard ? pg_now : '0) + (release_fr ? d_pg : '0);

    desc_fifo #(
        .WIDTH(DW),
        .DEPTH(N_DESC),
        .CW(QW)
    ) u_desc (
        .hclk(hclk),
        .hresetn(hresetn),
        .push(commit),
        .din(desc_in),
        .full(desc_full),
        .pop(release_fr),
        .dout(desc_out),
        .empty(desc_empty),
        .count(desc_cnt)
    );

    always_ff @(posedge hclk) begin
        if (wr_fire) begin
            mem_q[wr_addr] <= rx_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ing_q <= ING_IDLE;
            snap1_q <= CTRL_RESET;
            snap2_q <= CTRL_RESET;
            start_q <= '0;
        end else if (wr_fire) begin
            unique case (ing_q)
                ING_IDLE: begin
                    snap1_q <= ctrl1_q;
                    snap2_q <= ctrl2_q;
                    start_q <= np_q;
                    ing_q <= rx_last ? ING_IDLE : ING_RECV;
                end
                ING_RECV: begin
                    ing_q <= rx_last ? ING_IDLE : ING_RECV;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            np_q <= '0;
            cur_q <= '0;
            off_q <= '0;
            flen_q <= '0;
            fpg_q <= '0;
            free_q <= CW'(N_BUF);
        end else begin
            free_q <= free_d;
            if (wr_fire) begin
                cur_q <= alloc ? np_q : cur_q;
                off_q <= rx_last ? '0 : off_q + OW'(1);
                flen_q <= rx_last ? '0 : len_now;
                fpg_q <= rx_last ? '0 : pg_now;
                // a dropped frame hands its buffers straight back
                np_q <= discard ? fstart :
                        alloc ? np_q + PW'(1) : np_q;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            learn_valid_q <= 1'b0;
            learn_port_q <= 2'h0;
            drop_q <= '0;
            fwd_q <= '0;
        end else begin
            learn_valid_q <= end_fire
                && learn_on(rx_port, eff1, eff2);
            learn_port_q <= end_fire ? rx_port : learn_port_q;
            drop_q <= drop_q + CNT_W'(discard);
            fwd_q <= fwd_q + CNT_W'(commit);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            egr_q <= EGR_IDLE;
            idx_q <= '0;
            tx_data_q <= 8'h00;
        end else begin
            unique case (egr_q)
                EGR_IDLE: begin
                    if (egr_start) begin
                        egr_q <= EGR_SEND;
                        idx_q <= idx_next;
                        tx_data_q <= mem_q[byte_addr(d_start, idx_next)];
                    end
                end
                EGR_SEND: begin
                    if (release_fr) begin
                        egr_q <= EGR_IDLE;
                    end else if (tx_fire) begin
                        idx_q <= idx_next;
                        tx_data_q <= mem_q[byte_addr(d_start, idx_next)];
                    end
                end
            endcase
        end
    end

    // register bus: zero wait states, every answer OKAY
    // hsize is ignored: only whole-word transfers are expected
    wire bus_take = hsel && htrans[1] && hready;
    wire [31:0] status_word = (32'(free_q) << ST_FREE_LSB)
        | (32'(desc_cnt) << ST_QUEUED_LSB);

    // address decode shared by the read mux and the control writes
    wire hit_one = a_q == OFS_PORT_ONE_CTRL;
    wire hit_two = a_q == OFS_PORT_TWO_CTRL;
    wire hit_stat = a_q == OFS_POOL_STATUS;
    wire hit_drop = a_q == OFS_DROP_COUNT;
    wire hit_fwd = a_q == OFS_FWD_COUNT;
    wire [31:0] rd_val =
        hit_one ? 32'(ctrl1_q) :
        hit_two ? 32'(ctrl2_q) :
        hit_stat ? status_word :
        hit_drop ? 32'(drop_q) :
        hit_fwd ? 32'(fwd_q) : 32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rd_pend_q ? rd_val : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            a_q <= '0;
        end else begin
            wr_pend_q <= bus_take && hwrite;
            rd_pend_q <= bus_take && !hwrite;
            a_q <= bus_take ? haddr : a_q;
        end
    end

    // software may write at any time; live frames keep their snapshot
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl1_q <= CTRL_RESET;
            ctrl2_q <= CTRL_RESET;
        end else if (wr_pend_q) begin
            if (hit_one) begin
                ctrl1_q <= hwdata[CTRL_W-1:0];
            end
            if (hit_two) begin
                ctrl2_q <= hwdata[CTRL_W-1:0];
            end
        end
    end
endmodule : switch_stp_engine
`default_nettype wire

// ### verif/stp_engine_sva.sv
// port assertions for the switching engine
`default_nettype none
module stp_engine_sva
    import switch_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // register bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // streams
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_last,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic [2:0] tx_mask,
    input wire logic learn_valid
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [15:0] commit_q;
    logic [15:0] sent_q;
    sequence rx_end; rx_valid && rx_ready && rx_last; endsequence
    sequence tx_end; tx_valid && tx_ready && tx_last; endsequence
    // dropped frames count as committed, so only an upper bound
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            commit_q <= 16'h0;
            sent_q <= 16'h0;
        end else begin
            commit_q <= commit_q + 16'(rx_valid && rx_ready && rx_last);
            sent_q <= sent_q + 16'(tx_valid && tx_ready && tx_last);
        end
    end
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    rdata_idle_a: assert property (
        !$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    store_fwd_a: assert property (tx_valid |-> commit_q > sent_q)
        else $error("egress ahead of committed frames");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid
        && $stable(tx_data) && $stable(tx_mask) && $stable(tx_last))
        else $error("egress byte changed while stalled");
    frame_gap_a: assert property (tx_end |=> !tx_valid)
        else $error("no idle cycle after frame");
    mask_idle_a: assert property (!tx_valid |-> tx_mask == MASK_NONE)
        else $error("mask set while idle");
    mask_live_a: assert property (tx_valid |-> tx_mask != MASK_NONE)
        else $error("frame sent with empty mask");
    learn_cause_a: assert property (
        learn_valid |-> $past(rx_valid && rx_ready && rx_last))
        else $error("learn pulse without frame end");
    reset_quiet_a: assert property (
        $past(!hresetn) |-> !tx_valid && !learn_valid)
        else $error("activity right after reset");
    frame_cov: cover property (rx_end ##[1:60] tx_end);
endmodule : stp_engine_sva
bind switch_stp_engine stp_engine_sva i_stp_engine_sva (.hclk, .hresetn,
    .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp,
    .rx_valid, .rx_ready, .rx_last, .tx_valid, .tx_ready, .tx_data,
    .tx_last, .tx_mask, .learn_valid);
`default_nettype wire

// ### verif/egress_sink.sv
// host side egress sink with random stalls
`default_nettype none
module egress_sink (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // stream
    input wire logic hold,
    input wire logic tx_valid,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 16849;
    // takes every frame; discarding is left to host software
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= !hold && (!tx_valid || $random(seed) % 3 != 0);
        end
    end
endmodule : egress_sink
`default_nettype wire

// ### verif/switch_port_stp_state_control_test.sv
// self-checking bench for the spanning tree switching engine
`default_nettype none
module switch_port_stp_state_control_test;
    import switch_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NB = 8;
    localparam int SZ = 16;
    localparam logic [2:0] st_tab [4] = '{3'h1, 3'h1, 3'h0, 3'h6};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hold, sof;
    logic [7:0] haddr, rx_data, tx_data;
    logic [1:0] htrans, rx_port, learn_port, src;
    logic [2:0] hsize, rx_dest, tx_mask, c1, c2, dst;
    logic [31:0] hwdata, hrdata;
    logic rx_valid, rx_ready, rx_last, rx_override;
    logic tx_valid, tx_ready, tx_last, learn_valid;
    logic [8:0] exp_byte[$];
    logic [2:0] exp_mask[$];
    logic [1:0] exp_learn[$];
    int seed = 16849;
    int errors = 0;
    int checked = 0;
    int drops = 0;
    int fwds = 0;
    switch_stp_engine #(.N_BUF(NB), .BUF_SZ(SZ)) i_switch_stp_engine (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_valid,
        .rx_ready, .rx_data, .rx_last, .rx_port, .rx_dest, .rx_override,
        .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_mask, .learn_valid,
        .learn_port);
    egress_sink i_egress_sink (.hclk, .hresetn, .hold, .tx_valid, .tx_ready);
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check
    // which: 0 waits on hreadyout, 1 on rx_ready
    task automatic sync(input int which);
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while ((which ? rx_ready : hreadyout) !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            check(1'b0, "handshake timeout");
            final_report();
        end else begin
            @(posedge hclk);
        end
    endtask : sync
    task automatic ahb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'h2;
        sync(0);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        sync(0);
        r = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
        if (a == OFS_PORT_ONE_CTRL) c1 = d[2:0];
        if (a == OFS_PORT_TWO_CTRL) c2 = d[2:0];
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        check(r === e, $sformatf("read %h got %h want %h", a, r, e));
    endtask : rd_chk
    function automatic logic [2:0] gate(logic [1:0] s, logic [2:0] d,
            logic o, logic [2:0] a, logic [2:0] b);
        logic [2:0] c, m;
        if (s == PORT_HOST) return d & ~MASK_HOST;
        c = (s == PORT_ONE) ? a : b;
        if (!c[RX_EN_BIT]) return o ? MASK_HOST : MASK_NONE;
        m = d | (o ? MASK_HOST : MASK_NONE);
        if (!a[TX_EN_BIT]) m = m & ~MASK_ONE;
        if (!b[TX_EN_BIT]) m = m & ~MASK_TWO;
        return m & ~((s == PORT_ONE) ? MASK_ONE : MASK_TWO);
    endfunction : gate
    task automatic send_frame(input logic [1:0] s, input logic [2:0] d,
            input logic o, input int len, input logic mid);
        logic [2:0] s1, s2, m;
        logic [8:0] q[$];
        s1 = c1;
        s2 = c2;
        for (int i = 0; i < len; i++) begin
            q.push_back({i == len - 1, 8'($random(seed))});
            rx_valid <= 1'b1;
            {rx_last, rx_data} <= q[i];
            rx_port <= s;
            rx_dest <= d;
            rx_override <= o;
            sync(1);
            // valid stays up between bytes, drops only for a pause
            if (i == len - 1 || (mid && i == 0)) rx_valid <= 1'b0;
            // settings change inside the frame must not touch it
            if (mid && i == 0) wr(OFS_PORT_ONE_CTRL, 32'($random(seed)));
        end
        m = gate(s, d, o, s1, s2);
        if (m == MASK_NONE) drops++;
        else begin
            fwds++;
            exp_mask.push_back(m);
            foreach (q[k]) exp_byte.push_back(q[k]);
        end
        if (s == PORT_HOST || !(s == PORT_ONE ? s1[0] : s2[0]))
            exp_learn.push_back(s);
        rx_last <= 1'b0;
        @(posedge hclk);
    endtask : send_frame
    task automatic drain(input string name);
        int n;
        n = 0;
        while ((exp_byte.size() || exp_learn.size()) && n < 4000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 4000) begin
            check(1'b0, "drain timeout");
            final_report();
        end
        rd_chk(OFS_DROP_COUNT, 32'(drops));
        rd_chk(OFS_FWD_COUNT, 32'(fwds));
        $display("test %s done", name);
    endtask : drain
    always @(posedge hclk) begin
        if (hresetn && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_byte.size() == 0) check(1'b0, "unexpected byte");
            else begin
                if (sof) check(tx_mask === exp_mask.pop_front(), "mask");
                check({tx_last, tx_data} === exp_byte.pop_front(),
                    "data");
                sof = tx_last;
            end
        end
        if (hresetn && learn_valid === 1'b1) begin
            if (exp_learn.size() == 0) check(1'b0, "unexpected learn");
            else check(learn_port === exp_learn.pop_front(), "learn");
        end
    end
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, hold} = '0;
        {rx_valid, rx_data, rx_last, rx_port, rx_dest, rx_override} = '0;
        c1 = CTRL_RESET;
        c2 = CTRL_RESET;
        sof = 1'b1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(OFS_PORT_ONE_CTRL, 32'(CTRL_RESET));
        rd_chk(OFS_PORT_TWO_CTRL, 32'(CTRL_RESET));
        rd_chk(8'h20, 32'h0);
        rd_chk(OFS_POOL_STATUS, 32'(NB));
        for (int k = 0; k < 4; k++) begin
            wr(OFS_PORT_ONE_CTRL, 32'(st_tab[k]));
            send_frame(PORT_ONE, MASK_TWO, 1'b0, 5, 1'b0);
            send_frame(PORT_ONE, MASK_HOST, 1'b1, 3, 1'b0);
            send_frame(PORT_TWO, MASK_ONE | MASK_HOST, 1'b0, 4, 1'b0);
            if (k > 0) send_frame(PORT_HOST, MASK_ONE, 1'b0, 2, 1'b0);
        end
        drain("states");
        hold <= 1'b1;
        wr(OFS_PORT_ONE_CTRL, 32'h6);
        repeat (4) send_frame(PORT_ONE, MASK_TWO, 1'b0, SZ + 1, 1'b0);
        rd_chk(OFS_POOL_STATUS, 32'h0004_0000);
        @(negedge hclk);
        check(rx_ready === 1'b0, "pool full");
        @(posedge hclk);
        hold <= 1'b0;
        drain("pool");
        repeat (40) begin
            src = 2'(1 + $unsigned($random(seed)) % 3);
            dst = 3'($random(seed));
            if (src == PORT_HOST) dst = dst & {1'b0, c2[2], c1[2]};
            if ($random(seed) % 4 == 0) begin
                wr(OFS_PORT_TWO_CTRL, 32'($random(seed)));
            end
            send_frame(src, dst, 1'($random(seed)),
                1 + $unsigned($random(seed)) % 20, 1'($random(seed)));
        end
        drain("random");
        rd_chk(OFS_PORT_ONE_CTRL, 32'(c1));
        rd_chk(OFS_PORT_TWO_CTRL, 32'(c2));
        rd_chk(OFS_POOL_STATUS, 32'(NB));
        final_report();
    end
endmodule : switch_port_stp_state_control_test
`default_nettype wire
